/* src/fssic_core.sv */
/*
  Command interpreter of the flow sensor target: sleep entry and wake-up,
  stop of measurement, identifier read-out and checksummed data words.
  Assumes a byte-level bus front end that flags addresses, written bytes,
  read requests and stop conditions as one-cycle pulses in this clock domain.
*/
// Notes on behaviour
// - Sleep command accepted only from idle
// - Stop command reaches idle within half millisecond
// - Soft reset ignored while asleep
// - Own address with write bit wakes
// - Waking address not acknowledged; host polls
// - Identifier command honoured only from idle
// - Identifier returns product word, then serial
// - Serial decimal form year, week, sequence
// - Product number ends 8x prototype, 1x final
// - Checksum byte follows every returned word
// - CRC poly 31, init FF, no reflection
// - Flow word is signed sixteen bit
// - Temperature signed sixteen bit, scale 200
module fssic_core #(
  parameter logic [31:0] PROD_NUM = 32'h0A0B0C10, // Arbitrary value
  parameter logic [63:0] SERIAL_NUM = 64'h000000007D3AB741, // Arbitrary value
  parameter int STOP_CYCLES = fssic_pkg::STOP_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic i2c_stop, // Stop condition seen
  input wire logic addr_valid, // Address byte received
  input wire logic addr_match, // Address equals our own
  input wire logic addr_rw, // Direction bit, high for read
  input wire logic wr_valid, // Written byte available
  input wire logic [7:0] wr_data,
  input wire logic rd_req, // Host wants the next byte
  input wire logic meas_start, // Measurement started elsewhere
  input wire logic soft_reset, // General-call reset request
  input wire logic [15:0] flow_word, // Signed flow reading
  input wire logic [15:0] temp_word, // Signed temperature reading
  output logic addr_ack_reg, // Acknowledge for the address
  output logic rd_valid_reg, // Read byte ready
  output logic [7:0] rd_data_reg,
  output logic [3:0] mode_reg // Current operating mode
);

  localparam int SCW = $clog2(STOP_CYCLES + 1); // Stop counter width
  localparam logic [SCW-1:0] STOP_LAST = SCW'(STOP_CYCLES - 1);

  // ************************************************************
  // Reset release
  // ************************************************************
  logic rst_meta_reg; // First stage, read only by the second
  logic rst_sync_n; // Released reset for the rest of the block

  // Two stages keep the release clean against the clock
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_reg <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_n <= rst_meta_reg;
    end
  end

  // ************************************************************
  // Mode control and command capture
  // ************************************************************
  fssic_pkg::fssic_mode_t mode_q, mode_next; // Operating mode
  logic [SCW-1:0] stop_cnt_reg, stop_cnt_next; // Cycles since stop
  logic in_wr_reg, in_wr_next; // Inside a write transfer to us
  logic [1:0] wr_cnt_reg, wr_cnt_next; // Bytes taken in this write
  logic [7:0] cmd_hi_reg, cmd_hi_next; // First command byte
  logic ack_next;
  logic cmd_fire; // Second command byte arrives now
  logic [15:0] cmd_word;
  logic id_load; // Identifier read-out accepted
  logic wake_hdr; // Address write header while asleep
  logic rd_hdr; // Address read header acknowledged
  logic awake_ok; // Modes in which the address is answered

  assign mode_reg = mode_q;
  assign cmd_word = {cmd_hi_reg, wr_data};
  assign awake_ok = (mode_q == fssic_pkg::FSSIC_IDLE) || (mode_q == fssic_pkg::FSSIC_MEAS);
  assign wake_hdr = (mode_q == fssic_pkg::FSSIC_SLEEP) && addr_valid && addr_match && !addr_rw;
  assign rd_hdr = addr_valid && addr_match && addr_rw && awake_ok;
  // Commands only count as the second byte of a write to us
  assign cmd_fire = in_wr_reg && wr_valid && (wr_cnt_reg == 2'h1);

  // Next mode, command tracking and address answer
  always_comb begin
    mode_next = mode_q;
    stop_cnt_next = stop_cnt_reg;
    in_wr_next = in_wr_reg;
    wr_cnt_next = wr_cnt_reg;
    cmd_hi_next = cmd_hi_reg;
    id_load = 1'b0;
    // Sleep and stopping stay silent on the bus
    ack_next = addr_valid && addr_match && awake_ok;
    // Transfer framing
    if (i2c_stop) begin
      in_wr_next = 1'b0;
    end else if (addr_valid) begin
      in_wr_next = addr_match && !addr_rw && awake_ok;
      wr_cnt_next = 2'h0;
    end else if (in_wr_reg && wr_valid) begin
      if (wr_cnt_reg == 2'h0) begin
        cmd_hi_next = wr_data;
      end
      if (wr_cnt_reg != 2'h2) begin
        wr_cnt_next = wr_cnt_reg + 2'h1;
      end
    end
    case (mode_q)
      fssic_pkg::FSSIC_IDLE: begin
        if (cmd_fire && cmd_word == fssic_pkg::CMD_SLEEP) begin
          mode_next = fssic_pkg::FSSIC_SLEEP;
        end else if (cmd_fire && cmd_word == fssic_pkg::CMD_READ_ID) begin
          id_load = 1'b1;
        end else if (meas_start) begin
          mode_next = fssic_pkg::FSSIC_MEAS;
        end
      end
      fssic_pkg::FSSIC_MEAS: begin
        // Sleep and identifier commands fall through here unanswered
        if (cmd_fire && cmd_word == fssic_pkg::CMD_STOP) begin
          mode_next = fssic_pkg::FSSIC_STOPPING;
          stop_cnt_next = '0;
        end
      end
      fssic_pkg::FSSIC_STOPPING: begin
        // Heater power-down window, bounded by the stop time
        if (stop_cnt_reg == STOP_LAST) begin
          mode_next = fssic_pkg::FSSIC_IDLE;
        end else begin
          stop_cnt_next = stop_cnt_reg + 1'b1;
        end
      end
      fssic_pkg::FSSIC_SLEEP: begin
        // Only the write header wakes; the rest is ignored
        if (wake_hdr) begin
          mode_next = fssic_pkg::FSSIC_IDLE;
        end
      end
      default: begin
        mode_next = fssic_pkg::FSSIC_IDLE;
      end
    endcase
    // Soft reset works everywhere except in sleep
    if (soft_reset && mode_q != fssic_pkg::FSSIC_SLEEP) begin
      mode_next = fssic_pkg::FSSIC_IDLE;
      in_wr_next = 1'b0;
      id_load = 1'b0;
    end
  end

  // Registers of the control group
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      mode_q <= fssic_pkg::FSSIC_IDLE;
      stop_cnt_reg <= '0;
      in_wr_reg <= 1'b0;
      wr_cnt_reg <= 2'h0;
      cmd_hi_reg <= 8'h00;
      addr_ack_reg <= 1'b0;
    end else begin
      mode_q <= mode_next;
      stop_cnt_reg <= stop_cnt_next;
      in_wr_reg <= in_wr_next;
      wr_cnt_reg <= wr_cnt_next;
      cmd_hi_reg <= cmd_hi_next;
      addr_ack_reg <= ack_next;
    end
  end

  // ************************************************************
  // Read-out path
  // ************************************************************
  logic [15:0] buf_reg [fssic_pkg::ID_WORDS]; // Words queued for the host
  logic [15:0] buf_next [fssic_pkg::ID_WORDS];
  logic [2:0] nwords_reg, nwords_next; // Valid words in the buffer
  logic [2:0] widx_reg, widx_next; // Word being sent
  logic [1:0] pos_reg, pos_next; // Byte within the word group
  logic rd_valid_next;
  logic [7:0] rd_data_next;
  logic [15:0] cur_word; // Word under the read pointer
  logic [7:0] cur_crc; // Its checksum

  assign cur_word = (widx_reg < 3'(fssic_pkg::ID_WORDS)) ? buf_reg[widx_reg] : 16'h0000;

  // Checksum of the word now being sent
  fssic_crc8 #(.DATA_W(16)) u_crc (
    .data(cur_word),
    .crc(cur_crc)
  );

  // Buffer loading and byte sequencing
  always_comb begin
    for (int i = 0; i < fssic_pkg::ID_WORDS; i++) begin
      buf_next[i] = buf_reg[i];
    end
    nwords_next = nwords_reg;
    widx_next = widx_reg;
    pos_next = pos_reg;
    rd_valid_next = 1'b0;
    rd_data_next = rd_data_reg;
    if (id_load) begin
      // Product word first, then the serial number, high words first
      buf_next[0] = PROD_NUM[31:16];
      buf_next[1] = PROD_NUM[15:0];
      buf_next[2] = SERIAL_NUM[63:48];
      buf_next[3] = SERIAL_NUM[47:32];
      buf_next[4] = SERIAL_NUM[31:16];
      buf_next[5] = SERIAL_NUM[15:0];
      nwords_next = 3'(fssic_pkg::ID_WORDS);
      widx_next = 3'h0;
      pos_next = 2'h0;
    end else if (rd_hdr) begin
      widx_next = 3'h0;
      pos_next = 2'h0;
      // Snapshot so a word and its checksum always match
      if (mode_q == fssic_pkg::FSSIC_MEAS) begin
        buf_next[0] = flow_word;
        buf_next[1] = temp_word;
        nwords_next = 3'(fssic_pkg::MEAS_WORDS);
      end
    end else if (rd_req) begin
      rd_valid_next = 1'b1;
      if (widx_reg < nwords_reg) begin
        // Two data bytes, then their checksum
        case (pos_reg)
          2'h0: rd_data_next = cur_word[15:8];
          2'h1: rd_data_next = cur_word[7:0];
          default: rd_data_next = cur_crc;
        endcase
        if (pos_reg == fssic_pkg::POS_CRC) begin
          pos_next = 2'h0;
          widx_next = widx_reg + 3'h1;
        end else begin
          pos_next = pos_reg + 2'h1;
        end
      end else begin
        // Reading past the end returns filler rather than stale data
        rd_data_next = fssic_pkg::FILL_BYTE;
      end
    end
    if (soft_reset && mode_q != fssic_pkg::FSSIC_SLEEP) begin
      nwords_next = 3'h0;
    end
  end

  // Registers of the read-out group
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      for (int i = 0; i < fssic_pkg::ID_WORDS; i++) begin
        buf_reg[i] <= 16'h0000;
      end
      nwords_reg <= 3'h0;
      widx_reg <= 3'h0;
      pos_reg <= 2'h0;
      rd_valid_reg <= 1'b0;
      rd_data_reg <= 8'h00;
    end else begin
      for (int i = 0; i < fssic_pkg::ID_WORDS; i++) begin
        buf_reg[i] <= buf_next[i];
      end
      nwords_reg <= nwords_next;
      widx_reg <= widx_next;
      pos_reg <= pos_next;
      rd_valid_reg <= rd_valid_next;
      rd_data_reg <= rd_data_next;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  logic [15:0] hist_reg; // Last two bytes sent, helper only
  logic crc_slot_reg; // Byte just sent was a checksum slot
  logic [7:0] hist_crc; // Independent checksum of the history
  logic [7:0] ex_crc; // Known-answer checksum
  localparam logic [63:0] DEC10 = 64'h00000002540BE400;
  localparam logic [63:0] DEC6 = 64'h00000000000F4240;
  localparam logic [63:0] SER_WEEK = (SERIAL_NUM / DEC6) % 64'h0000000000000064;

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      hist_reg <= 16'h0000;
      crc_slot_reg <= 1'b0;
    end else begin
      crc_slot_reg <= rd_req && !rd_hdr && !id_load && (widx_reg < nwords_reg)
        && (pos_reg == fssic_pkg::POS_CRC);
      if (rd_valid_reg) begin
        hist_reg <= {hist_reg[7:0], rd_data_reg};
      end
    end
  end

  fssic_crc8 #(.DATA_W(16)) u_hist_crc (
    .data(hist_reg),
    .crc(hist_crc)
  );

  fssic_crc8 #(.DATA_W(16)) u_ex_crc (
    .data(fssic_pkg::CRC_EX_DATA),
    .crc(ex_crc)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_n);

  sequence s_wake_hdr;
    wake_hdr;
  endsequence

  sequence s_id_start;
    rd_req && !rd_hdr && !id_load && nwords_reg == 3'(fssic_pkg::ID_WORDS)
      && widx_reg == 3'h0 && pos_reg == 2'h0;
  endsequence

  sequence s_meas_hdr;
    rd_hdr && !id_load && mode_q == fssic_pkg::FSSIC_MEAS && !soft_reset;
  endsequence

  chk_sleep_refused: assert property (
    cmd_fire && cmd_word == fssic_pkg::CMD_SLEEP && mode_q != fssic_pkg::FSSIC_IDLE
      && mode_q != fssic_pkg::FSSIC_SLEEP |=> mode_q != fssic_pkg::FSSIC_SLEEP)
    else $error("sleep entered outside idle");
  chk_sleep_entry: assert property (
    cmd_fire && cmd_word == fssic_pkg::CMD_SLEEP && mode_q == fssic_pkg::FSSIC_IDLE
      && !soft_reset |=> mode_q == fssic_pkg::FSSIC_SLEEP ##1 !addr_ack_reg)
    else $error("sleep not entered from idle");
  chk_stop_bound: assert property (
    mode_q == fssic_pkg::FSSIC_STOPPING |-> stop_cnt_reg <= STOP_LAST)
    else $error("stop window overran");
  chk_stop_done: assert property (
    mode_q == fssic_pkg::FSSIC_STOPPING && stop_cnt_reg == STOP_LAST
      |=> mode_q == fssic_pkg::FSSIC_IDLE)
    else $error("idle not reached after stop");
  chk_sleep_keep: assert property (
    mode_q == fssic_pkg::FSSIC_SLEEP && soft_reset && !wake_hdr
      |=> mode_q == fssic_pkg::FSSIC_SLEEP)
    else $error("soft reset left sleep");
  chk_wake_idle: assert property (
    s_wake_hdr |=> mode_q == fssic_pkg::FSSIC_IDLE)
    else $error("write header did not wake");
  chk_wake_nack: assert property (
    s_wake_hdr |=> !addr_ack_reg)
    else $error("waking address acknowledged");
  chk_id_refused: assert property (
    cmd_fire && cmd_word == fssic_pkg::CMD_READ_ID && mode_q != fssic_pkg::FSSIC_IDLE
      && !soft_reset && !addr_valid |=> $stable(nwords_reg))
    else $error("identifier loaded outside idle");
  chk_id_first: assert property (
    s_id_start |=> rd_valid_reg && rd_data_reg == PROD_NUM[31:24])
    else $error("identifier does not start with product number");
  chk_serial_fmt: assert property (
    SERIAL_NUM < DEC10 && SER_WEEK >= 64'h1 && SER_WEEK <= 64'h35)
    else $error("serial number not in year week sequence form");
  chk_prod_class: assert property (
    PROD_NUM[7:4] == 4'h1 || PROD_NUM[7:4] == 4'h8)
    else $error("product number class digit invalid");
  chk_crc_byte: assert property (
    rd_valid_reg && crc_slot_reg |-> rd_data_reg == hist_crc)
    else $error("checksum byte does not match preceding word");
  chk_crc_example: assert property (
    ex_crc == fssic_pkg::CRC_EX_RES)
    else $error("checksum known answer wrong");
  chk_flow_word: assert property (
    s_meas_hdr |=> buf_reg[0] == $past(flow_word) && nwords_reg == 3'h2)
    else $error("flow word not captured");
  chk_temp_word: assert property (
    s_meas_hdr |=> buf_reg[1] == $past(temp_word))
    else $error("temperature word not captured");

endmodule : fssic_core

/* src/fssic_pkg.sv */
/*
  Shared constants for the flow sensor command interpreter: command codes,
  checksum definition, timing counts, read-out layout and the mode encoding.
  Assumes a 100 MHz core clock; every timing count below is derived from it.
*/
package fssic_pkg;

  // ************************************************************
  // Command codes, first byte on the wire is the upper byte
  // ************************************************************
  localparam logic [15:0] CMD_SLEEP = 16'h3677; // Enter sleep
  localparam logic [15:0] CMD_READ_ID = 16'hE102; // Read product identifier
  localparam logic [15:0] CMD_STOP = 16'h3FF9; // Stop continuous measurement

  // ************************************************************
  // Checksum definition
  // ************************************************************
  localparam logic [7:0] CRC_POLY = 8'h31; // x8 + x5 + x4 + 1
  localparam logic [7:0] CRC_INIT = 8'hFF; // Start value
  localparam logic [7:0] CRC_XOR_OUT = 8'h00; // Final xor
  localparam logic [15:0] CRC_EX_DATA = 16'hBEEF; // Known-answer input
  localparam logic [7:0] CRC_EX_RES = 8'h92; // Known-answer result

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 10; // 100 MHz core clock
  localparam int STOP_TIME_NS = 500000; // Longest time to reach idle after stop
  // Longest time, so rounded down
  localparam int STOP_CYCLES = STOP_TIME_NS / CLK_PERIOD_NS;
  localparam int WAKE_TIME_MS = 16; // Typical wake-up the host should allow

  // ************************************************************
  // Read-out layout
  // ************************************************************
  localparam int ID_WORDS = 6; // Two product words, four serial words
  localparam int MEAS_WORDS = 2; // Flow word then temperature word
  localparam logic [1:0] POS_CRC = 2'h2; // Third byte of each group
  localparam logic [7:0] FILL_BYTE = 8'hFF; // Read past the end of data

  // ************************************************************
  // Host-side conversion figures, carried for reference
  // ************************************************************
  localparam int FLOW_SCALE = 170; // Per slm, oxygen, air and mixture
  localparam int FLOW_OFFSET = -24576; // Subtracted before scaling
  localparam int TEMP_SCALE = 200; // Per degree Celsius
  localparam int TEMP_OFFSET = 0; // No offset

  // ************************************************************
  // Operating modes, one-hot
  // ************************************************************
  typedef enum logic [3:0] {
    FSSIC_IDLE = 4'h1,
    FSSIC_MEAS = 4'h2,
    FSSIC_STOPPING = 4'h4,
    FSSIC_SLEEP = 4'h8
  } fssic_mode_t;

endpackage : fssic_pkg

/* src/fssic_crc8.sv */
/*
  Combinational CRC-8 over one data word, most significant bit first.
  Assumes the caller registers the result if timing needs it.
*/
module fssic_crc8 #(
  parameter int DATA_W = 16
) (
  input wire logic [DATA_W-1:0] data,
  output logic [7:0] crc
);

  // ************************************************************
  // Bitwise shift register, unrolled by the loop
  // ************************************************************
  always_comb begin
    logic [7:0] c;
    c = fssic_pkg::CRC_INIT;
    for (int i = DATA_W - 1; i >= 0; i--) begin
      // Feedback taps the polynomial when the outgoing bit differs
      if (c[7] ^ data[i]) begin
        c = {c[6:0], 1'b0} ^ fssic_pkg::CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    crc = c ^ fssic_pkg::CRC_XOR_OUT;
  end

endmodule : fssic_crc8

/* dv/fssic_host_model.sv */
/*
  Host controller model that polls the flow sensor command interpreter at
  its byte-level front-end pulses: headers, written bytes, stops, reads.
  Assumes one clock shared with the design; every request is set with a
  non-blocking assignment at a rising edge and answered one edge later.
*/
module fssic_host_model (
  input wire logic clk,
  output logic i2c_stop,
  output logic addr_valid,
  output logic addr_match,
  output logic addr_rw,
  output logic wr_valid,
  output logic [7:0] wr_data,
  output logic rd_req,
  input wire logic addr_ack_reg,
  input wire logic rd_valid_reg,
  input wire logic [7:0] rd_data_reg
);
  timeunit 1ns;
  timeprecision 1ps;

  // ************************************************************
  // Bus cycles
  // ************************************************************
  // Quiet bus at time zero
  initial begin
    {i2c_stop, addr_valid, addr_match, addr_rw, wr_valid, rd_req} = 6'h00;
    wr_data = 8'h00;
  end

  // Address header; qualifiers are inverted once released, never left stale
  task automatic pulse_hdr(input logic match, input logic rw, output logic ack);
    @(posedge clk);
    addr_valid <= 1'b1;
    addr_match <= match;
    addr_rw <= rw;
    @(posedge clk);
    addr_valid <= 1'b0;
    addr_match <= ~match;
    addr_rw <= ~rw;
    #1;
    ack = addr_ack_reg;
  endtask : pulse_hdr

  // One written byte
  task automatic put_byte(input logic [7:0] b);
    @(posedge clk);
    wr_valid <= 1'b1;
    wr_data <= b;
    @(posedge clk);
    wr_valid <= 1'b0;
    wr_data <= ~b;
  endtask : put_byte

  // Stop condition ends the transfer
  task automatic end_xfer();
    @(posedge clk);
    i2c_stop <= 1'b1;
    @(posedge clk);
    i2c_stop <= 1'b0;
    // Step off the edge so callers see settled outputs
    #1;
  endtask : end_xfer

  // Command code travels in a write transfer, upper byte first
  task automatic send_cmd(input logic [15:0] code);
    logic ack;
    pulse_hdr(1'b1, 1'b0, ack);
    put_byte(code[15:8]);
    put_byte(code[7:0]);
    end_xfer();
  endtask : send_cmd

  // One read byte, taken at the edge that answers the request
  task automatic get_byte(output logic [7:0] b, output logic ok);
    @(posedge clk);
    rd_req <= 1'b1;
    @(posedge clk);
    rd_req <= 1'b0;
    #1;
    ok = rd_valid_reg;
    b = rd_data_reg;
  endtask : get_byte

  // Word plus its checksum byte
  task automatic get_word(output logic [15:0] w, output logic [7:0] c, output logic ok);
    logic ok0;
    logic ok1;
    get_byte(w[15:8], ok0);
    get_byte(w[7:0], ok1);
    get_byte(c, ok);
    ok = ok & ok0 & ok1;
  endtask : get_word

  // Wake-up: first header is not acknowledged, so poll with a bound
  task automatic wake(output int polls);
    logic ack;
    polls = 0;
    ack = 1'b0;
    while (ack !== 1'b1 && polls < 4) begin
      pulse_hdr(1'b1, 1'b0, ack);
      end_xfer();
      polls++;
    end
  endtask : wake

  // Host-side checksum used to check a received word
  function automatic logic [7:0] crc8(input logic [15:0] w);
    logic [7:0] c;
    c = 8'hFF;
    for (int i = 15; i >= 0; i--) begin
      c = (c[7] ^ w[i]) ? ((c << 1) ^ 8'h31) : (c << 1);
    end
    return c;
  endfunction : crc8

  // Host-side flow conversion in hundredths of a standard litre per minute
  function automatic int flow_centi(input logic [15:0] w);
    return ((int'($signed(w)) - fssic_pkg::FLOW_OFFSET) * 100) / fssic_pkg::FLOW_SCALE;
  endfunction : flow_centi
endmodule : fssic_host_model

/* dv/flow_sensor_sleep_id_crc_bench.sv */
/*
  Self-checking bench for the command interpreter: identifier read-out,
  measurement words, stop, sleep entry, soft reset and wake-up polling.
  Assumes the host model drives the bus side; the bench drives the rest.
*/
module flow_sensor_sleep_id_crc_bench;
  timeunit 1ns;
  timeprecision 1ps;

  // ************************************************************
  // Setup
  // ************************************************************
  localparam logic [31:0] T_PROD = 32'h5A3C0012; // Arbitrary value, ends in 1x
  localparam logic [63:0] T_SER = 64'h0000000089FC18EA; // Arbitrary, decimal 2315000042
  localparam int T_STOP = 8; // Short stop time keeps the run brief
  logic clk, nrst, meas_start, soft_reset, i2c_stop, addr_valid, addr_match;
  logic addr_rw, wr_valid, rd_req, addr_ack_reg, rd_valid_reg, ack, ok;
  logic [7:0] wr_data, rd_data_reg, b, c;
  logic [15:0] flow_word, temp_word, w;
  logic [3:0] mode_reg;
  logic [63:0] ser;
  int n_fail, check_count, cycles, seed, n;

  fssic_core #(.PROD_NUM(T_PROD), .SERIAL_NUM(T_SER), .STOP_CYCLES(T_STOP)) dut_u (
    .clk(clk), .nrst(nrst), .i2c_stop(i2c_stop), .addr_valid(addr_valid),
    .addr_match(addr_match), .addr_rw(addr_rw), .wr_valid(wr_valid), .wr_data(wr_data),
    .rd_req(rd_req), .meas_start(meas_start), .soft_reset(soft_reset),
    .flow_word(flow_word), .temp_word(temp_word), .addr_ack_reg(addr_ack_reg),
    .rd_valid_reg(rd_valid_reg), .rd_data_reg(rd_data_reg), .mode_reg(mode_reg));

  fssic_host_model host_u (
    .clk(clk), .i2c_stop(i2c_stop), .addr_valid(addr_valid), .addr_match(addr_match),
    .addr_rw(addr_rw), .wr_valid(wr_valid), .wr_data(wr_data), .rd_req(rd_req),
    .addr_ack_reg(addr_ack_reg), .rd_valid_reg(rd_valid_reg), .rd_data_reg(rd_data_reg));

  // Free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ************************************************************
  // Helpers
  // ************************************************************
  // Verdict and end of run, the only exit
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim

  // Single compare point
  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask : check

  // Read one word and compare word and checksum against the expectation
  task automatic chk_word(input logic [15:0] exp);
    host_u.get_word(w, c, ok);
    check(ok, 1'b1, "read answer");
    check(w, exp, "data word");
    check(c, host_u.crc8(exp), "checksum");
  endtask : chk_word

  // One-cycle pulse on a side input, sel 1 is soft reset, 0 measurement start
  task automatic strobe(input bit sel);
    @(posedge clk);
    if (sel) soft_reset <= 1'b1;
    else meas_start <= 1'b1;
    @(posedge clk);
    soft_reset <= 1'b0;
    meas_start <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : strobe

  // Cuts a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      end_sim();
    end
  end

  // ************************************************************
  // Scenarios
  // ************************************************************
  initial begin
    seed = 32'h0000A726;
    {nrst, meas_start, soft_reset} = 3'h0;
    flow_word = 16'h0000;
    temp_word = 16'h0000;
    {n_fail, check_count, cycles} = '0;
    ser = 64'h0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check(mode_reg, fssic_pkg::FSSIC_IDLE, "mode after reset");
    // Identifier from idle, then fill beyond the last word
    host_u.send_cmd(fssic_pkg::CMD_READ_ID);
    host_u.pulse_hdr(1'b1, 1'b1, ack);
    check(ack, 1'b1, "read header ack");
    for (int i = 0; i < 6; i++) begin
      if (i < 2) chk_word(T_PROD[16*(1-i) +: 16]);
      else chk_word(T_SER[16*(5-i) +: 16]);
      ser = {ser[47:0], w};
    end
    check(ser / 64'h5F5E100, 64'h17, "serial year");
    check((ser / 64'hF4240) % 64'h64, 64'hF, "serial week");
    host_u.get_byte(b, ok);
    check(b, fssic_pkg::FILL_BYTE, "past the end");
    // Measuring refuses sleep and identifier
    strobe(1'b0);
    check(mode_reg, fssic_pkg::FSSIC_MEAS, "measuring");
    host_u.send_cmd(fssic_pkg::CMD_SLEEP);
    check(mode_reg, fssic_pkg::FSSIC_MEAS, "sleep refused");
    host_u.send_cmd(fssic_pkg::CMD_READ_ID);
    check(mode_reg, fssic_pkg::FSSIC_MEAS, "id refused");
    // Signed words, extremes first then random
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      flow_word <= (k == 0) ? 16'h8000 : 16'($random(seed));
      temp_word <= (k == 0) ? 16'h7FFF : 16'($random(seed));
      host_u.pulse_hdr(1'b1, 1'b1, ack);
      chk_word(flow_word);
      if (k == 0) check(host_u.flow_centi(w), -4818, "flow converted");
      chk_word(temp_word);
    end
    // Stop, refused address while stopping, idle within the stop time
    host_u.send_cmd(fssic_pkg::CMD_STOP);
    check(mode_reg, fssic_pkg::FSSIC_STOPPING, "stopping");
    host_u.pulse_hdr(1'b1, 1'b0, ack);
    check(ack, 1'b0, "no ack while stopping");
    n = 0;
    while (mode_reg !== fssic_pkg::FSSIC_IDLE && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    // Four edges pass between the stop command edge and the polling loop
    check(n + 4 <= T_STOP, 1'b1, "idle in time");
    // Sleep only after stop, soft reset and read header ignored, wake by poll
    host_u.send_cmd(fssic_pkg::CMD_SLEEP);
    check(mode_reg, fssic_pkg::FSSIC_SLEEP, "asleep");
    strobe(1'b1);
    check(mode_reg, fssic_pkg::FSSIC_SLEEP, "reset ignored");
    host_u.pulse_hdr(1'b1, 1'b1, ack);
    host_u.pulse_hdr(1'b0, 1'b0, ack);
    check(mode_reg, fssic_pkg::FSSIC_SLEEP, "no wake on read or other");
    host_u.wake(n);
    check(n, 2, "polls to wake");
    check(mode_reg, fssic_pkg::FSSIC_IDLE, "awake");
    // Soft reset while measuring empties the read buffer
    strobe(1'b0);
    host_u.pulse_hdr(1'b1, 1'b1, ack);
    strobe(1'b1);
    check(mode_reg, fssic_pkg::FSSIC_IDLE, "reset to idle");
    host_u.get_byte(b, ok);
    check(b, fssic_pkg::FILL_BYTE, "buffer emptied");
    end_sim();
  end
endmodule : flow_sensor_sleep_id_crc_bench
